// ==== hdl/mm_port_pkg.sv ====
// Shared constants for the memory-mapped transfer port and its two ends.
package mm_port_pkg;
    // ****************************************************************
    // Widths and limits
    // ****************************************************************
    localparam int DATA_W_MIN      = 8;
    localparam int DATA_W_MAX      = 1024;
    localparam int PENDING_MIN     = 1;
    localparam int PENDING_MAX     = 64;
    localparam int PENDING_DEF     = 2;
    localparam int WAIT_TIME_MIN   = 0;
    localparam int WAIT_TIME_MAX   = 1000;
    localparam int READ_WAIT_DEF   = 1;
    localparam int WRITE_WAIT_DEF  = 0;
    localparam int LATENCY_DEF     = 2;
    localparam int MEM_DEPTH_DEF   = 16;

    // ****************************************************************
    // Slave stall modes
    // ****************************************************************
    localparam int MODE_WAITREQ    = 0;
    localparam int MODE_FIXED      = 1;
    localparam int MODE_PIPELINED  = 2;
endpackage

// ==== hdl/mm_port_if.sv ====
// Interface joining the requesting end and the slave end of the port.
`timescale 1ns/10ps
interface mm_port_if #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic clk
);
    logic [ADDR_W-1:0]   address;
    logic [DATA_W/8-1:0] byteenable;
    logic                read;
    logic                write;
    logic [DATA_W-1:0]   writedata;
    logic                begintransfer;
    logic [DATA_W-1:0]   readdata;
    logic                readdatavalid;
    logic                waitrequest;

    modport slave (
        input  clk,
        input  address,
        input  byteenable,
        input  read,
        input  write,
        input  writedata,
        input  begintransfer,
        output readdata,
        output readdatavalid,
        output waitrequest
    );

    modport master (
        input  clk,
        output address,
        output byteenable,
        output read,
        output write,
        output writedata,
        output begintransfer,
        input  readdata,
        input  readdatavalid,
        input  waitrequest
    );
endinterface

// ==== hdl/mm_slave_end.sv ====
// Slave end: a small memory behind the port with selectable stall mode.
// Functional notes
// RULE1 - Logic reacts only to the one clock
// RULE2 - Data word width 8 to 1024 bits
// RULE3 - Waitrequest used for both reads and writes
// RULE4 - Stall raised within the request cycle
// RULE5 - Requester holds request during waitrequest
// RULE6 - Transfer completes at edge after release
// RULE7 - Begintransfer marks only first request cycle
// RULE8 - Fixed wait counts act like waitrequest
// RULE9 - Zero wait-states answer in request cycle
// RULE10 - Writes are never pipelined
// RULE11 - Requester may issue reads before data returns
// RULE12 - One wait-state halves peak throughput
// RULE13 - Pipelined slave accepts one read per cycle
// RULE14 - Readdatavalid no earlier than next cycle
// RULE15 - Read data returned in accept order
// RULE16 - Variable latency slave uses waitrequest
// RULE17 - Slave caps outstanding reads by stalling
// RULE18 - Writes stalled until outstanding reads return
// RULE19 - Write hitting pending read gives undefined data
// RULE20 - Waitrequest is always eventually released
// RULE21 - Pending read limit is 1 to 64
// RULE22 - Fixed wait times range 0 to 1000
// RULE23 - Counter tracks outstanding reads
`timescale 1ns/10ps
module mm_slave_end
    import mm_port_pkg::*;
#(
    parameter int ADDR_W      = 8,
    parameter int DATA_W      = 32,
    parameter int MODE        = MODE_PIPELINED,
    parameter int READ_WAIT   = READ_WAIT_DEF,
    parameter int WRITE_WAIT  = WRITE_WAIT_DEF,
    parameter int MAX_PENDING = PENDING_DEF,
    parameter int LATENCY     = LATENCY_DEF,
    parameter int MEM_DEPTH   = MEM_DEPTH_DEF
) (
    input  wire logic      REF_CLK,
    input  wire logic      SYS_RST,
    mm_port_if.slave       BUS,
    output logic [7:0]     PENDING_COUNT,
    output logic           BUSY
);
    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    initial begin
        if (DATA_W < DATA_W_MIN || DATA_W > DATA_W_MAX || DATA_W % 8 != 0)
            $error("DATA_W must be a multiple of 8 from 8 to 1024"); // [RULE2]
        if (MAX_PENDING < PENDING_MIN || MAX_PENDING > PENDING_MAX)
            $error("MAX_PENDING out of range"); // [RULE21]
        if (READ_WAIT < WAIT_TIME_MIN || READ_WAIT > WAIT_TIME_MAX ||
            WRITE_WAIT < WAIT_TIME_MIN || WRITE_WAIT > WAIT_TIME_MAX)
            $error("Wait time out of range"); // [RULE22]
        if (LATENCY < 1 || LATENCY > 64)
            $error("LATENCY must be 1 to 64");
        if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << ADDR_W))
            $error("MEM_DEPTH does not fit the address");
        if ((MEM_DEPTH & (MEM_DEPTH - 1)) != 0)
            $error("MEM_DEPTH must be a power of two");
        if (MODE != MODE_WAITREQ && MODE != MODE_FIXED &&
            MODE != MODE_PIPELINED)
            $error("MODE is not a known stall mode");
    end

    // Wide enough for the longest fixed wait, which the count never passes.
    localparam int CW = $clog2(WAIT_TIME_MAX + 1);
    localparam int IW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

    // ****************************************************************
    // Storage
    // ****************************************************************
    localparam int LANES = DATA_W / 8;

    logic [DATA_W-1:0] mem_word;
    logic [IW-1:0]     index;
    logic              accept_read;
    logic              accept_write;
    logic [CW-1:0]     wait_cnt_reg;

    // Only the low address bits select a word; higher bits alias.
    assign index = BUS.address[IW-1:0];

    // Each byte lane keeps its own array, so a write changes only the
    // lanes that its byteenable selects and no lane has two writers.
    for (genvar b = 0; b < LANES; b++) begin : g_lane
        logic [7:0] lane_mem_reg [MEM_DEPTH];

        always_ff @(posedge REF_CLK) begin
            if (accept_write && BUS.byteenable[b]) begin
                lane_mem_reg[index] <= BUS.writedata[b*8 +: 8]; // [RULE6]
            end
        end

        assign mem_word[b*8 +: 8] = lane_mem_reg[index];
    end

    // ****************************************************************
    // Fixed and plain wait-state counting
    // ****************************************************************
    // The counter runs while a request is held; release comes after
    // exactly the configured number of cycles, so stalls are bounded.
    logic [CW-1:0] need;
    always_comb begin
        need = BUS.read ? CW'(READ_WAIT) : CW'(WRITE_WAIT);
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            wait_cnt_reg <= '0;
        end else if (MODE != MODE_PIPELINED &&
                     (BUS.read || BUS.write) && !BUS.waitrequest) begin
            wait_cnt_reg <= '0; // [RULE6]
        end else if (MODE != MODE_PIPELINED && (BUS.read || BUS.write)) begin
            wait_cnt_reg <= wait_cnt_reg + CW'(1); // [RULE8] [RULE20]
        end
    end

    // ****************************************************************
    // Pipelined read tracking
    // ****************************************************************
    logic [7:0] pending_reg;
    logic [LATENCY-1:0]  lat_valid_reg;
    logic [DATA_W-1:0]   lat_data_reg [LATENCY];
    logic pipe_stall;

    // Waitrequest depends only on inputs and local registers, so it is
    // decided inside the request cycle.
    // Writes wait for every pending read to drain. That costs throughput
    // on mixed traffic but keeps a write from overtaking a read in flight.
    always_comb begin
        pipe_stall = 1'b0;
        if (BUS.read && pending_reg >= 8'(MAX_PENDING)
            && !lat_valid_reg[LATENCY-1])
            pipe_stall = 1'b1; // [RULE17]
        if (BUS.write && pending_reg != 8'h00)
            pipe_stall = 1'b1; // [RULE18] [RULE10]
    end

    always_comb begin
        unique case (MODE)
            MODE_PIPELINED: BUS.waitrequest = pipe_stall; // [RULE16]
            default: BUS.waitrequest = (BUS.read || BUS.write) &&
                                       (wait_cnt_reg < need); // [RULE4] [RULE3] [RULE12]
        endcase
    end

    assign accept_read  = BUS.read && !BUS.waitrequest;
    assign accept_write = BUS.write && !BUS.waitrequest;

    // A pipelined read enters a shift line, one per cycle, so the port
    // takes back-to-back reads and returns them in acceptance order.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            lat_valid_reg <= '0;
        end else if (MODE == MODE_PIPELINED) begin
            // A shift by one stays legal for a latency of a single cycle.
            lat_valid_reg <= (lat_valid_reg << 1) |
                             LATENCY'(accept_read); // [RULE13] [RULE15]
        end
    end

    // The word is taken as the read is accepted, so a later write to the
    // same address leaves the returned word at its old value.
    always_ff @(posedge REF_CLK) begin
        lat_data_reg[0] <= mem_word; // [RULE19]
    end

    for (genvar s = 1; s < LATENCY; s++) begin : g_stage
        always_ff @(posedge REF_CLK) begin
            lat_data_reg[s] <= lat_data_reg[s-1];
        end
    end

    // The count rises on an accepted read and falls as its word leaves,
    // so it equals the reads the master is still waiting for.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            pending_reg <= 8'h00;
        end else if (MODE == MODE_PIPELINED) begin
            pending_reg <= pending_reg + 8'(accept_read)
                           - 8'(lat_valid_reg[LATENCY-1]); // [RULE23]
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************

    // Non-pipelined modes present read data combinationally from the
    // memory during the releasing cycle; with zero waits this is the
    // request cycle itself, which costs clock rate.
    always_comb begin
        unique case (MODE)
            MODE_PIPELINED: begin
                BUS.readdata      = lat_data_reg[LATENCY-1];
                BUS.readdatavalid = lat_valid_reg[LATENCY-1]; // [RULE14]
            end
            default: begin
                BUS.readdata      = mem_word; // [RULE9]
                BUS.readdatavalid = accept_read;
            end
        endcase
    end

    // BUSY tells a user that reads are pending, so in pipelined mode a write would now be held off.
    assign PENDING_COUNT = pending_reg;
    assign BUSY          = (pending_reg != 8'h00); // [RULE1]
endmodule

// ==== hdl/mm_master_end.sv ====
// Requesting end: turns user commands into port transfers.
`timescale 1ns/10ps
module mm_master_end
    import mm_port_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input  wire logic              REF_CLK,
    input  wire logic              SYS_RST,
    mm_port_if.master              BUS,
    input  wire logic              CMD_VALID,
    input  wire logic              CMD_WRITE,
    input  wire logic [ADDR_W-1:0] CMD_ADDR,
    input  wire logic [DATA_W-1:0] CMD_WDATA,
    input  wire logic [DATA_W/8-1:0] CMD_BE,
    output logic                   CMD_READY,
    output logic                   RSP_VALID,
    output logic [DATA_W-1:0]      RSP_DATA
);
    initial begin
        if (DATA_W < DATA_W_MIN || DATA_W > DATA_W_MAX || DATA_W % 8 != 0)
            $error("DATA_W must be a multiple of 8 from 8 to 1024"); // [RULE2]
    end

    // ****************************************************************
    // Request holding
    // ****************************************************************
    logic first_reg;
    logic busy;
    assign busy      = BUS.read || BUS.write;
    // A new command is taken when idle or as the held one completes,
    // so reads may follow each other every cycle.
    assign CMD_READY = !busy || !BUS.waitrequest; // [RULE11]

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            BUS.read  <= 1'b0;
            BUS.write <= 1'b0;
            first_reg <= 1'b0;
        end else if (CMD_READY) begin
            BUS.read  <= CMD_VALID && !CMD_WRITE;
            BUS.write <= CMD_VALID && CMD_WRITE;
            first_reg <= CMD_VALID;
        end else begin
            first_reg <= 1'b0; // [RULE7]
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            BUS.address    <= '0;
            BUS.writedata  <= '0;
            BUS.byteenable <= '0;
        end else if (CMD_READY && CMD_VALID) begin
            BUS.address    <= CMD_ADDR; // [RULE5]
            BUS.writedata  <= CMD_WDATA;
            BUS.byteenable <= CMD_BE;
        end
    end

    assign BUS.begintransfer = first_reg;

    // ****************************************************************
    // Read data capture
    // ****************************************************************
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            RSP_VALID <= 1'b0;
            RSP_DATA  <= '0;
        end else begin
            RSP_VALID <= BUS.readdatavalid; // [RULE6]
            if (BUS.readdatavalid)
                RSP_DATA <= BUS.readdata;
        end
    end
endmodule

// ==== tb/mm_port_sva.sv ====
// Checker that watches the port between the requesting and slave ends.
`timescale 1ns/10ps
module mm_port_sva #(
    parameter int ADDR_W      = 8,
    parameter int DATA_W      = 32,
    parameter int MAX_PENDING = 2
) (
    input wire logic                clk,
    input wire logic                SYS_RST,
    input wire logic [ADDR_W-1:0]   address,
    input wire logic [DATA_W/8-1:0] byteenable,
    input wire logic                read,
    input wire logic                write,
    input wire logic [DATA_W-1:0]   writedata,
    input wire logic                begintransfer,
    input wire logic                readdatavalid,
    input wire logic                waitrequest
);
    logic       acc;
    logic [7:0] pend_reg;
    logic [7:0] pend_next;

    // ****************************************************************
    // Outstanding read count seen on the wires
    // ****************************************************************
    assign acc = read & ~waitrequest;
    always_comb begin
        pend_next = pend_reg + 8'(acc) - 8'(readdatavalid);
    end
    always_ff @(posedge clk) begin
        if (SYS_RST) begin
            pend_reg <= 8'h00;
        end else begin
            pend_reg <= pend_next;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (SYS_RST);

    sequence s_stalled;
        (read || write) && waitrequest;
    endsequence
    sequence s_accept_rd;
        read && !waitrequest;
    endsequence

    // ****************************************************************
    // Transfer rules
    // ****************************************************************
    a_hold_request: assert property (s_stalled |=> $stable(address) &&
        $stable(read) && $stable(write) && $stable(writedata) &&
        $stable(byteenable))
        else $error("request changed during a wait-state");
    a_begin_once: assert property (begintransfer && waitrequest |=>
        !begintransfer) else $error("begintransfer held in wait-state");
    a_no_overlap: assert property (!(read && write))
        else $error("read and write raised together");
    a_data_latency: assert property (s_accept_rd |-> ##2 readdatavalid)
        else $error("read data not returned after two cycles");
    a_data_cause: assert property (readdatavalid |-> $past(acc, 2))
        else $error("read data without an accepted read");
    a_pending_cap: assert property (pend_reg <= MAX_PENDING)
        else $error("outstanding reads above the limit");
    a_read_fast: assert property (read && pend_reg < MAX_PENDING |->
        !waitrequest) else $error("read stalled below the limit");
    a_full_stall: assert property (read && pend_reg == MAX_PENDING &&
        !readdatavalid |-> waitrequest) else $error("read taken when full");
    a_write_held: assert property (write && pend_reg != 0 |->
        waitrequest) else $error("write taken with reads pending");
    a_write_free: assert property (write && pend_reg == 0 |->
        !waitrequest) else $error("write stalled with nothing pending");
    a_stall_ends: assert property (s_stalled |-> ##[1:8] !waitrequest)
        else $error("stall not released");
endmodule

// ==== tb/tb.sv ====
// Self-checking bench joining the requesting end to the slave end.
`timescale 1ns/10ps
module tb;
    import mm_port_pkg::*;
    logic        REF_CLK;
    logic        SYS_RST;
    logic        cmd_valid;
    logic        cmd_write;
    logic [7:0]  cmd_addr;
    logic [31:0] cmd_wdata;
    logic [3:0]  cmd_be;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [31:0] rsp_data;
    logic [7:0]  pending_count;
    logic        busy;
    logic [31:0] model_mem [16];
    logic [31:0] expect_q [$];
    int          failures;
    int          checks_done;
    int          seed;

    mm_port_if #(.ADDR_W(8), .DATA_W(32)) mm_port_if_inst (.clk(REF_CLK));
    mm_slave_end #(.MODE(MODE_PIPELINED)) mm_slave_end_inst (
        .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .BUS(mm_port_if_inst.slave),
        .PENDING_COUNT(pending_count), .BUSY(busy));
    mm_master_end mm_master_end_inst (
        .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .BUS(mm_port_if_inst.master),
        .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
        .CMD_WDATA(cmd_wdata), .CMD_BE(cmd_be), .CMD_READY(cmd_ready),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
    mm_port_sva #(.ADDR_W(8), .DATA_W(32), .MAX_PENDING(PENDING_DEF))
        mm_port_sva_inst (
        .clk(REF_CLK), .SYS_RST(SYS_RST),
        .address(mm_port_if_inst.address),
        .byteenable(mm_port_if_inst.byteenable),
        .read(mm_port_if_inst.read), .write(mm_port_if_inst.write),
        .writedata(mm_port_if_inst.writedata),
        .begintransfer(mm_port_if_inst.begintransfer),
        .readdatavalid(mm_port_if_inst.readdatavalid),
        .waitrequest(mm_port_if_inst.waitrequest));

    task automatic note_err(input string msg);
        failures++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            note_err($sformatf("read %h expected %h", got, exp));
        end
    endtask
    task automatic check_idle(input logic [7:0] cnt, input logic bsy);
        checks_done++;
        if (cnt !== 8'h00 || bsy !== 1'b0) begin
            note_err("slave not idle after drain");
        end
    endtask
    task automatic stop_test();
        $display("checks_done %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Called at a rising edge; returns at the edge that takes the command.
    // The memory model follows command order, since the requesting end
    // never takes a command before the previous transfer was accepted.
    task automatic send(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] be);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_be <= be;
        do @(negedge REF_CLK); while (cmd_ready !== 1'b1);
        @(posedge REF_CLK);
        if (wr) begin
            for (int i = 0; i < 4; i++) begin
                if (be[i]) model_mem[a[3:0]][8*i +: 8] = d[8*i +: 8];
            end
        end else begin
            expect_q.push_back(model_mem[a[3:0]]);
        end
    endtask

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    always @(posedge REF_CLK) begin
        if (rsp_valid === 1'b1) begin
            if (expect_q.size() == 0) begin
                note_err("response with nothing expected");
            end else begin
                check_word(expect_q.pop_front(), rsp_data);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge REF_CLK);
        note_err("timeout");
        stop_test();
    end

    initial begin
        seed = 39522;
        failures = 0;
        checks_done = 0;
        SYS_RST = 1'b1;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 8'h00;
        cmd_wdata = 32'h0;
        cmd_be = 4'h0;
        repeat (6) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        @(posedge REF_CLK);
        for (int k = 0; k < 16; k++) begin
            send(1'b1, 8'(k), $random(seed), 4'hf);
        end
        for (int k = 0; k < 16; k++) begin
            send(1'b0, 8'(k), 32'h0, 4'hf);
        end
        send(1'b1, 8'h03, $random(seed), 4'h5);
        send(1'b0, 8'h03, 32'h0, 4'hf);
        for (int k = 0; k < 80; k++) begin
            send(1'($random(seed)), 8'($random(seed)), $random(seed),
                 4'($random(seed)));
        end
        cmd_valid <= 1'b0;
        repeat (10) @(posedge REF_CLK);
        check_idle(pending_count, busy);
        stop_test();
    end
endmodule
